/* dv/can_interrupt_error_flags_bench.sv */
/* Self-checking bench of cief_top over its register bus.
   Assumes cief_can_node drives the bus receive pin. */
`timescale 1ns/1ps

module can_interrupt_error_flags_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cief_pkg::cief_err_s err = '0;
	cief_pkg::cief_evt_s evt = '0;
	logic [31:0] buf_full = '0;
	logic sleep = 1'b0;
	logic can_rx;
	logic [7:0] awa = '0;
	logic [7:0] ara = '0;
	logic [31:0] wd = '0;
	logic [3:0] ws = 4'hF;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wrdy, bv, arr, rv, irq;
	logic [1:0] br, rr, wr_r, rd_r;
	logic [31:0] rdat, rd_d;
	int err_total = 0;
	int total_checks = 0;

	always #20 clk = ~clk;

	cief_can_node cief_can_node_i (.o_rx(can_rx));
	cief_top cief_top_i (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_ERR_STATE(err),
		.I_EVENT(evt), .I_BUF_FULL(buf_full), .I_SLEEP(sleep),
		.I_CAN_RX(can_rx), .I_AWADDR(awa), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws),
		.I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(br), .O_BVALID(bv),
		.I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
		.O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr),
		.O_RVALID(rv), .I_RREADY(rry), .O_IRQ(irq));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
		end while (!bv);
		bry <= 1'b0;
		wr_r = br;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (!rv);
		rry <= 1'b0;
		rd_d = rdat;
		rd_r = rr;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_d, e);
	endtask : rdc

	task automatic pulse(input cief_pkg::cief_evt_s v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= '0;
	endtask : pulse

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		for (int a = 0; a < 20; a += 4)
			rdc(a[7:0], 32'h0);
		chk(irq, 32'h0);
		$display("reset done");
	endtask : t_reset

	task automatic t_state;
		logic [4:0] v;
		for (int i = 0; i < 5; i++) begin
			v = 5'h10 >> i;
			@(posedge clk);
			err <= v;
			repeat (3) @(posedge clk);
			rdc(8'h00, {18'h0, v, v[1] | v[0], 8'h20});
		end
		@(posedge clk);
		err <= 5'h1F;
		repeat (3) @(posedge clk);
		wr(8'h00, 32'h0);
		rdc(8'h00, 32'h3F00);
		@(posedge clk);
		err <= 5'h00;
		wr(8'h00, 32'hFFFF_FFFF);
		rdc(8'h00, 32'h0);
		$display("state done");
	endtask : t_state

	task automatic t_events;
		logic [9:0] ev [4] = '{10'h200, 10'h100, 10'h080, 10'h040};
		logic [7:0] fl [4] = '{8'h80, 8'h08, 8'h02, 8'h01};
		logic [31:0] e;
		e = '0;
		for (int i = 0; i < 4; i++) begin
			pulse(ev[i]);
			e = e | fl[i];
			rdc(8'h00, e);
		end
		wr(8'h00, 32'hFF);
		rdc(8'h00, e);
		@(posedge clk);
		ws <= 4'h2;
		wr(8'h00, 32'h0);
		rdc(8'h00, e);
		@(posedge clk);
		ws <= 4'hF;
		wr(8'h00, 32'h7F);
		rdc(8'h00, 32'h0B);
		wr(8'h00, 32'h0);
		rdc(8'h0C, 32'hAB);
		rdc(8'h0C, 32'h0);
		$display("events done");
	endtask : t_events

	task automatic t_ovf;
		@(posedge clk);
		buf_full <= 32'h0010_0008;
		pulse(10'h023);
		pulse(10'h025);
		pulse(10'h034);
		rdc(8'h04, 32'h8);
		rdc(8'h08, 32'h10);
		rdc(8'h00, 32'h4);
		wr(8'h08, 32'hFFFF_FFFF);
		rdc(8'h08, 32'h10);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h0);
		rdc(8'h08, 32'h0);
		$display("overflow done");
	endtask : t_ovf

	task automatic t_wake;
		cief_can_node_i.wake();
		rdc(8'h00, 32'h0);
		@(posedge clk);
		sleep <= 1'b1;
		cief_can_node_i.wake();
		rdc(8'h00, 32'h40);
		wr(8'h00, 32'h0);
		$display("wake done");
	endtask : t_wake

	task automatic t_irq;
		rdc(8'h0C, 32'h44);
		wr(8'h10, 32'hFF);
		chk(wr_r, 32'h0);
		rdc(8'h10, 32'hEF);
		chk(rd_r, 32'h0);
		wr(8'h10, 32'h80);
		pulse(10'h100);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
		pulse(10'h200);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		rdc(8'h0C, 32'h88);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
		rd(8'h20);
		chk(rd_r, 32'h2);
		wr(8'h20, 32'hFF);
		chk(wr_r, 32'h2);
		$display("irq done");
	endtask : t_irq

	task automatic t_rst;
		pulse(10'h200);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk(irq, 32'h0);
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h0);
		rdc(8'h0C, 32'h0);
		rdc(8'h10, 32'h0);
		$display("reset again done");
	endtask : t_rst

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_state();
		t_events();
		t_ovf();
		t_wake();
		t_irq();
		t_rst();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule : can_interrupt_error_flags_bench

/* dv/cief_can_node.sv */
/* Model of another node on the CAN bus.
   Assumes a recessive-high receive pin held by the bus pull-up. */
`timescale 1ns/1ps

module cief_can_node (
	output logic o_rx
);
	initial o_rx = 1'b1;

	// a dominant stretch off the clock grid, then recessive again
	task automatic wake;
		#310 o_rx = 1'b0;
		#2000 o_rx = 1'b1;
		#400;
	endtask : wake
endmodule : cief_can_node

/* dv/cief_top_properties.sv */
/* Checker of bus timing and flag readback of cief_top.
   Assumes it is bound onto cief_top and sees only its ports. */
`timescale 1ns/1ps

module cief_chk #(
	parameter int AW = 8
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [AW-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_RVALID,
	input wire logic I_RREADY
);
	logic [AW-1:0] rd_addr;

	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RST_N);

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N)
			rd_addr <= '0;
		else if (I_ARVALID && O_ARREADY)
			rd_addr <= I_ARADDR;
	end

	sequence s_wr_take;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_rd_flags;
		O_RVALID && rd_addr == 0;
	endsequence

	a_wr_answer: assert property (s_wr_take |-> ##2 O_BVALID)
		else $error("write answer late");
	a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
		else $error("bvalid dropped");
	a_b_block: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write taken while busy");
	a_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer late");
	a_r_hold: assert property (O_RVALID && !I_RREADY |=>
		O_RVALID && $stable(O_RDATA))
		else $error("read data not held");
	a_r_block: assert property (O_RVALID |-> !O_ARREADY)
		else $error("read taken while busy");
	a_flag_gaps: assert property (s_rd_flags |->
		O_RDATA[31:14] == 0 && !O_RDATA[4])
		else $error("unused flag bit set");
	a_warn_sum: assert property (s_rd_flags |->
		O_RDATA[8] == (O_RDATA[10] | O_RDATA[9]))
		else $error("warning summary wrong");
	a_unmapped: assert property (O_RVALID && rd_addr > 8'h10 |->
		O_RRESP == 2'h2 && O_RDATA == 0)
		else $error("unmapped read answered");
endmodule : cief_chk

bind cief_top cief_chk #(.AW(AW)) cief_chk_i (
	.I_CLOCK, .I_RST_N, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
	.O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
	.O_RRESP, .O_RVALID, .I_RREADY);

/* rtl/cief_flag.sv */
/*
 * Bank of sticky flags: hardware sets, a clear request clears.
 * Assumes set and clear are single-cycle terms of the same clock.
 */
`timescale 1ns/1ps

module cief_flag #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	output logic [W-1:0] o_q
);

	// set wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_q <= RST;
		end else begin
			o_q <= (o_q & ~i_clr) | i_set;
		end
	end

endmodule : cief_flag

/* rtl/cief_pkg.sv */
/*
 * Types shared by the CAN interrupt and error flag block.
 * Assumes the offsets and positions come from cief_regs.svh.
 */
package cief_pkg;

	// fault-confinement state from the protocol engine
	typedef struct packed {
		logic tx_bus_off_state;
		logic tx_error_passive_state;
		logic rx_error_passive_state;
		logic tx_error_warning_state;
		logic rx_error_warning_state;
	} cief_err_s;

	// one-cycle events from the protocol engine
	typedef struct packed {
		logic invalid_message;
		logic fifo_almost_full;
		logic rx_done;
		logic tx_done;
		logic rx_store;
		logic [4:0] rx_store_buf;
	} cief_evt_s;

endpackage : cief_pkg

/* rtl/cief_regs.svh */
/*
 * Register offsets, field positions and reset values of the CAN
 * interrupt and error flag block.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef CIEF_REGS_SVH
`define CIEF_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------
`define CIEF_OFS_FLAGS 8'h00
`define CIEF_OFS_OVF_LO 8'h04
`define CIEF_OFS_OVF_HI 8'h08
`define CIEF_OFS_IRQ_STAT 8'h0C
`define CIEF_OFS_IRQ_MASK 8'h10

// ----------------------------------------------------------------------
// flag register field positions
// ----------------------------------------------------------------------
`define CIEF_B_TX_BUS_OFF 13
`define CIEF_B_TX_PASSIVE 12
`define CIEF_B_RX_PASSIVE 11
`define CIEF_B_TX_WARN 10
`define CIEF_B_RX_WARN 9
`define CIEF_B_ANY_WARN 8
`define CIEF_B_INVALID 7
`define CIEF_B_WAKEUP 6
`define CIEF_B_ERROR 5
`define CIEF_B_FIFO 3
`define CIEF_B_RX_OVF 2
`define CIEF_B_RX_BUF 1
`define CIEF_B_TX_BUF 0

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define CIEF_NBUF 32
`define CIEF_HALF 16
`define CIEF_FLAG_RST 8'h00
`define CIEF_OVF_RST 32'h0000_0000
`define CIEF_MASK_RST 8'h00
`define CIEF_EVT_BITS 8'hEF
`define CIEF_RESP_OKAY 2'h0
`define CIEF_RESP_SLVERR 2'h2

`endif

/* rtl/cief_sync3.sv */
/*
 * Three-stage synchroniser for asynchronous inputs.
 * Assumes the output may change only when stages two and three agree.
 */
`timescale 1ns/1ps

module cief_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
		end else begin
			s1 <= i_d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a bit only once stages two and three agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_q <= RST;
		end else begin
			for (int k = 0; k < W; k++) begin
				if (s2[k] == s3[k]) begin
					o_q[k] <= s3[k];
				end
			end
		end
	end

endmodule : cief_sync3

/* rtl/cief_top.sv */
/*
 * CAN interrupt and error flag block with an AXI4-Lite register slave.
 * Holds the fault-confinement status, the sticky event flags, the
 * per-buffer overflow bits, and a read-clear interrupt status with its
 * mask behind one level interrupt output.
 * Assumes state and event inputs come from the protocol engine on
 * I_CLOCK; only the bus receive pin is asynchronous.
 * Assumes a bus master with at most one write and one read open.
 */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
// What this block does
// - status bit 13 reads 1 while transmitter is bus-off.
// - status bit 12 reads 1 while transmitter is error-passive.
// - status bit 11 reads 1 while receiver is error-passive.
// - status bit 10 reads 1 while transmitter is error-warning.
// - status bit 9 reads 1 while receiver is error-warning.
// - status bit 8 reads 1 when either side is error-warning.
// - invalid message sets sticky flag bit 7 until software clears.
// - bus wake-up activity sets sticky flag bit 6.
// - entering any error state of bits 13..8 sets sticky bit 5.
// - receive FIFO almost full sets sticky flag bit 3.
// - receive buffer overflow sets sticky flag bit 2.
// - flags clear only by writing zero; bits 13..8 read-only; reset zero.
// - bits 15, 14 and 4 read zero and ignore writes.
// - storing into a full buffer sets that buffer's overflow bit.
`timescale 1ns/1ps
`include "cief_regs.svh"

module cief_top #(
	parameter int AW = 8
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire cief_pkg::cief_err_s I_ERR_STATE,
	input wire cief_pkg::cief_evt_s I_EVENT,
	input wire logic [`CIEF_NBUF-1:0] I_BUF_FULL,
	input wire logic I_SLEEP,
	input wire logic I_CAN_RX,
	input wire logic [AW-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [AW-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_IRQ
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	cief_pkg::cief_err_s err;
	logic [5:0] state_bits;
	logic [5:0] state_prev;
	logic can_rx;
	logic can_rx_prev;
	logic [AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic rd_go;
	logic [7:0] evt;
	logic [7:0] flag_clr;
	logic [7:0] flags;
	logic [`CIEF_NBUF-1:0] ovf_set;
	logic [`CIEF_NBUF-1:0] ovf_clr;
	logic [`CIEF_NBUF-1:0] ovf;
	logic [7:0] irq_clr;
	logic [7:0] irq_stat;
	logic [7:0] irq_mask;
	logic overflow;
	logic [15:0] flag_word;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [15:0] wr_clr;

	// byte-lane write-zero-clear mask for a 16-bit register
	function automatic logic [15:0] zero_clr(input logic [31:0] d,
		input logic [3:0] s);
		zero_clr[15:8] = s[1] ? ~d[15:8] : 8'h00;
		zero_clr[7:0] = s[0] ? ~d[7:0] : 8'h00;
	endfunction : zero_clr

	// clear mask of the word held for the pending write
	assign wr_clr = zero_clr(w_data, w_strb);

	// ------------------------------------------------------------------
	// bus pin synchroniser
	// ------------------------------------------------------------------
	cief_sync3 #(
		.W(1),
		.RST(1'b1)
	) u_rx_sync (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_d(I_CAN_RX),
		.o_q(can_rx)
	);

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			can_rx_prev <= 1'b1;
		end else begin
			can_rx_prev <= can_rx;
		end
	end

	// ------------------------------------------------------------------
	// fault-confinement state
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			err <= '0;
			state_prev <= 6'h00;
		end else begin
			err <= I_ERR_STATE;
			state_prev <= state_bits;
		end
	end

	assign state_bits = {
		err.tx_bus_off_state,
		err.tx_error_passive_state,
		err.rx_error_passive_state,
		err.tx_error_warning_state,
		err.rx_error_warning_state,
		err.tx_error_warning_state | err.rx_error_warning_state
	};

	// ------------------------------------------------------------------
	// event collection
	// ------------------------------------------------------------------
	assign overflow = I_EVENT.rx_store && I_BUF_FULL[I_EVENT.rx_store_buf];

	always_comb begin
		evt = 8'h00;
		evt[`CIEF_B_INVALID] = I_EVENT.invalid_message;
		// dominant edge while asleep counts as wake-up
		evt[`CIEF_B_WAKEUP] = I_SLEEP && can_rx_prev && !can_rx;
		evt[`CIEF_B_ERROR] = |(state_bits & ~state_prev);
		evt[`CIEF_B_FIFO] = I_EVENT.fifo_almost_full;
		evt[`CIEF_B_RX_OVF] = overflow;
		evt[`CIEF_B_RX_BUF] = I_EVENT.rx_done;
		evt[`CIEF_B_TX_BUF] = I_EVENT.tx_done;
		evt = evt & `CIEF_EVT_BITS;
	end

	always_comb begin
		ovf_set = '0;
		if (overflow) begin
			ovf_set[I_EVENT.rx_store_buf] = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------------
	assign wr_go = !O_AWREADY && !O_WREADY && !O_BVALID;

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_AWREADY <= 1'b1;
			aw_addr <= '0;
		end else if (I_AWVALID && O_AWREADY) begin
			O_AWREADY <= 1'b0;
			aw_addr <= I_AWADDR;
		end else if (O_BVALID && I_BREADY) begin
			O_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WREADY <= 1'b1;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (I_WVALID && O_WREADY) begin
			O_WREADY <= 1'b0;
			w_data <= I_WDATA;
			w_strb <= I_WSTRB;
		end else if (O_BVALID && I_BREADY) begin
			O_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BVALID <= 1'b0;
			O_BRESP <= `CIEF_RESP_OKAY;
		end else if (wr_go) begin
			O_BVALID <= 1'b1;
			case (aw_addr)
				`CIEF_OFS_FLAGS,
				`CIEF_OFS_OVF_LO,
				`CIEF_OFS_OVF_HI,
				`CIEF_OFS_IRQ_STAT,
				`CIEF_OFS_IRQ_MASK: begin
					O_BRESP <= `CIEF_RESP_OKAY;
				end
				default: begin
					O_BRESP <= `CIEF_RESP_SLVERR;
				end
			endcase
		end else if (O_BVALID && I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// write effects: zero clears, ones ignored; the irq mask takes the written byte with bit 4 forced to zero
	// ------------------------------------------------------------------
	always_comb begin
		flag_clr = 8'h00;
		ovf_clr = '0;
		if (wr_go && aw_addr == `CIEF_OFS_FLAGS) begin
			// high byte is read-only state
			flag_clr = wr_clr[7:0];
		end
		if (wr_go && aw_addr == `CIEF_OFS_OVF_LO) begin
			ovf_clr[`CIEF_HALF-1:0] = wr_clr;
		end
		if (wr_go && aw_addr == `CIEF_OFS_OVF_HI) begin
			ovf_clr[`CIEF_NBUF-1:`CIEF_HALF] = wr_clr;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_mask <= `CIEF_MASK_RST;
		end else if (wr_go && aw_addr == `CIEF_OFS_IRQ_MASK && w_strb[0]) begin
			irq_mask <= w_data[7:0] & `CIEF_EVT_BITS;
		end
	end

	// ------------------------------------------------------------------
	// sticky flags
	// ------------------------------------------------------------------
	cief_flag #(
		.W(8),
		.RST(`CIEF_FLAG_RST)
	) u_flags (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_set(evt),
		.i_clr(flag_clr),
		.o_q(flags)
	);

	cief_flag #(
		.W(`CIEF_NBUF),
		.RST(`CIEF_OVF_RST)
	) u_ovf (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_set(ovf_set),
		.i_clr(ovf_clr),
		.o_q(ovf)
	);

	// interrupt status: cleared by reading it
	assign irq_clr = (rd_go && I_ARADDR == `CIEF_OFS_IRQ_STAT) ?
		8'hFF : 8'h00;

	cief_flag #(
		.W(8),
		.RST(`CIEF_FLAG_RST)
	) u_irq (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_set(evt),
		.i_clr(irq_clr),
		.o_q(irq_stat)
	);

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_stat & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	assign rd_go = I_ARVALID && O_ARREADY;

	// bits 15, 14 and 4 stay zero
	assign flag_word = {2'b00, state_bits, flags & `CIEF_EVT_BITS};

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = `CIEF_RESP_OKAY;
		case (I_ARADDR)
			`CIEF_OFS_FLAGS: begin
				next_rdata[15:0] = flag_word;
			end
			`CIEF_OFS_OVF_LO: begin
				next_rdata[15:0] = ovf[`CIEF_HALF-1:0];
			end
			`CIEF_OFS_OVF_HI: begin
				next_rdata[15:0] = ovf[`CIEF_NBUF-1:`CIEF_HALF];
			end
			`CIEF_OFS_IRQ_STAT: begin
				next_rdata[7:0] = irq_stat;
			end
			`CIEF_OFS_IRQ_MASK: begin
				next_rdata[7:0] = irq_mask;
			end
			default: begin
				next_rresp = `CIEF_RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= `CIEF_RESP_OKAY;
		end else if (rd_go) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= next_rdata;
			O_RRESP <= next_rresp;
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

endmodule : cief_top
